// *** logic/timer_pkg.sv ***
package timer_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EDGE = 8'h04;
  localparam logic [7:0] OFF_CMP0 = 8'h08;
  localparam logic [7:0] OFF_CMP1 = 8'h0c;
  localparam logic [7:0] OFF_CAP0 = 8'h10;
  localparam logic [7:0] OFF_CAP1 = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions in the control word
  // ----------------------------------------------------------------------
  localparam int CE_POS = 0;
  localparam int MODE_LSB = 1;
  localparam int REWRITE_POS = 4;

  // ----------------------------------------------------------------------
  // Mode and edge codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_INTERVAL = 3'h0;
  localparam logic [2:0] MODE_EVENT = 3'h1;
  localparam logic [2:0] MODE_PWM_TRIG = 3'h2;
  localparam logic [2:0] MODE_PULSE = 3'h6;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------------
  // Counter values and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CNT_CLEAR = 16'h0000;
  localparam logic [15:0] CNT_TOP = 16'hffff;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam logic [15:0] CMP_RESET = 16'h0000;

  typedef struct packed {
    logic rewrite_mode;
    logic [2:0] mode;
    logic count_enable;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] sel_one;
    logic [1:0] sel_zero;
  } edge_ctl_t;

  localparam ctrl_t CTRL_RESET = 5'h00;
  localparam edge_ctl_t EDGE_RESET = 4'h0;

  typedef enum logic {ST_STOPPED, ST_COUNTING} run_state_t;

endpackage

// *** logic/timer_event_counter.sv ***
// Local design decisions: the register offsets and the APB slave port.
module timer_event_counter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Count clock tick and external inputs
  input wire logic count_tick,
  input wire logic capture_input_zero,
  input wire logic capture_input_one,
  input wire logic ext_trigger,
  // Interrupt requests, one-cycle pulses
  output logic compare_zero_interrupt,
  output logic compare_one_interrupt,
  output logic [1:0] capture_interrupt_request,
  // Timer outputs
  output logic timer_output_zero,
  output logic timer_output_one,
  output logic pwm_output_pin
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev, input logic cur);
    case (sel)
      timer_pkg::EDGE_RISE: edge_hit = !prev && cur;
      timer_pkg::EDGE_FALL: edge_hit = prev && !cur;
      timer_pkg::EDGE_BOTH: edge_hit = prev ^ cur;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == timer_pkg::OFF_CTRL) || (a == timer_pkg::OFF_EDGE) ||
                  (a == timer_pkg::OFF_CMP0) || (a == timer_pkg::OFF_CMP1) ||
                  (a == timer_pkg::OFF_CAP0) || (a == timer_pkg::OFF_CAP1) ||
                  (a == timer_pkg::OFF_COUNT);
  endfunction

  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  timer_pkg::ctrl_t ctrl;
  timer_pkg::edge_ctl_t edge_ctl;
  timer_pkg::run_state_t state;
  logic [15:0] cmp0;
  logic [15:0] cmp1;
  logic [15:0] buf0;
  logic [15:0] buf1;
  logic [15:0] cap0;
  logic [15:0] cap1;
  logic [15:0] counter;
  logic xfer_req;
  logic prev_in0;
  logic prev_in1;
  logic prev_trig;
  logic [31:0] rd_val;

  // APB access phase; the slave never inserts wait states.
  logic access;
  logic wr_ctrl;
  logic wr_edge;
  logic wr_cmp0;
  logic wr_cmp1;

  assign access = psel && penable;
  assign pready = access;
  assign pslverr = access && !addr_mapped(paddr);
  assign wr_ctrl = access && pwrite && (paddr == timer_pkg::OFF_CTRL);
  assign wr_edge = access && pwrite && (paddr == timer_pkg::OFF_EDGE);
  assign wr_cmp0 = access && pwrite && (paddr == timer_pkg::OFF_CMP0);
  assign wr_cmp1 = access && pwrite && (paddr == timer_pkg::OFF_CMP1);

  // ----------------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------------
  logic running;
  logic start;
  logic ev_edge;
  logic advance;
  logic cap_hit0;
  logic cap_hit1;
  logic trig;
  logic match0;
  logic match1;
  logic is_pulse;
  logic is_event;
  logic is_pwm;
  logic is_interval;

  assign running = (state == timer_pkg::ST_COUNTING) && ctrl.count_enable;
  assign start = ctrl.count_enable && (state == timer_pkg::ST_STOPPED);
  assign is_pulse = ctrl.mode == timer_pkg::MODE_PULSE;
  assign is_event = ctrl.mode == timer_pkg::MODE_EVENT;
  assign is_pwm = ctrl.mode == timer_pkg::MODE_PWM_TRIG;
  assign is_interval = ctrl.mode == timer_pkg::MODE_INTERVAL;
  // External events always arrive on capture input zero.
  assign ev_edge = edge_hit(edge_ctl.sel_zero, prev_in0, capture_input_zero);
  assign advance = running && (is_event ? ev_edge : count_tick);
  assign cap_hit0 = running && is_pulse && ev_edge;
  assign cap_hit1 = running && is_pulse &&
                    edge_hit(edge_ctl.sel_one, prev_in1, capture_input_one);
  assign trig = running && is_pwm &&
                edge_hit(edge_ctl.sel_one, prev_trig, ext_trigger);
  assign match0 = advance && !is_pulse && (counter == buf0);
  assign match1 = advance && !is_pulse && (counter == buf1);

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      prev_in0 <= 1'b0;
      prev_in1 <= 1'b0;
      prev_trig <= 1'b0;
    end
    else
    begin
      prev_in0 <= capture_input_zero;
      prev_in1 <= capture_input_one;
      prev_trig <= ext_trigger;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      ctrl <= timer_pkg::CTRL_RESET;
      edge_ctl <= timer_pkg::EDGE_RESET;
      cmp0 <= timer_pkg::CMP_RESET;
      cmp1 <= timer_pkg::CMP_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= pwdata[4:0];
      if (wr_edge)
        edge_ctl <= pwdata[3:0];
      if (wr_cmp0)
        cmp0 <= pwdata[15:0];
      if (wr_cmp1)
        cmp1 <= pwdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      state <= timer_pkg::ST_STOPPED;
    else
    begin
      case (state)
        timer_pkg::ST_STOPPED:
          if (ctrl.count_enable)
            state <= timer_pkg::ST_COUNTING;
        timer_pkg::ST_COUNTING:
          if (!ctrl.count_enable)
            state <= timer_pkg::ST_STOPPED;
        default: state <= timer_pkg::ST_STOPPED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Compare buffers and batch transfer
  // ----------------------------------------------------------------------
  // A write to compare one wins over a transfer in the same cycle, so a
  // value written at a transfer point is never dropped.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      xfer_req <= 1'b0;
    else if (wr_cmp1 && !ctrl.rewrite_mode)
      xfer_req <= 1'b1;
    else if (wr_ctrl && pwdata[timer_pkg::REWRITE_POS])
      xfer_req <= 1'b0;
    else if (match0 && !trig)
      xfer_req <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      buf0 <= timer_pkg::CMP_RESET;
      buf1 <= timer_pkg::CMP_RESET;
    end
    else if (start)
    begin
      buf0 <= cmp0;
      buf1 <= cmp1;
    end
    else if (ctrl.rewrite_mode && (wr_cmp0 || wr_cmp1))
    begin
      if (wr_cmp0)
        buf0 <= pwdata[15:0];
      if (wr_cmp1)
        buf1 <= pwdata[15:0];
    end
    else if (match0 && !trig && xfer_req)
    begin
      buf0 <= cmp0;
      buf1 <= cmp1;
    end
  end

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  // When lowered compare zero sits below the count, the plain 16-bit
  // increment runs through FFFFH to 0000H before it can match again.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      counter <= timer_pkg::CNT_CLEAR;
    else if (!ctrl.count_enable)
      counter <= is_event ? timer_pkg::CNT_TOP : timer_pkg::CNT_CLEAR;
    else if (start)
      counter <= timer_pkg::CNT_CLEAR;
    else if (is_pulse)
    begin
      if (cap_hit0 || cap_hit1)
        counter <= timer_pkg::CNT_CLEAR;
      else if (advance)
        counter <= counter + timer_pkg::CNT_STEP;
    end
    else if (trig)
      counter <= timer_pkg::CNT_CLEAR;
    else if (match0)
      counter <= timer_pkg::CNT_CLEAR;
    else if (advance)
      counter <= counter + timer_pkg::CNT_STEP;
  end

  // ----------------------------------------------------------------------
  // Capture, interrupts and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      cap0 <= timer_pkg::CNT_CLEAR;
      cap1 <= timer_pkg::CNT_CLEAR;
      capture_interrupt_request <= 2'h0;
    end
    else
    begin
      if (cap_hit0)
        cap0 <= counter;
      if (cap_hit1)
        cap1 <= counter;
      capture_interrupt_request <= {cap_hit1, cap_hit0};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      compare_zero_interrupt <= 1'b0;
      compare_one_interrupt <= 1'b0;
      timer_output_zero <= 1'b0;
      timer_output_one <= 1'b0;
    end
    else
    begin
      compare_zero_interrupt <= match0 && !trig;
      compare_one_interrupt <= match1 && !trig;
      if (match0 && !trig)
        timer_output_zero <= !timer_output_zero;
      if (match1 && !trig && is_interval)
        timer_output_one <= !timer_output_one;
    end
  end

  // The active phase runs from a cycle start or trigger to the compare one
  // match, so a trigger in the active phase stretches it and one after the match cuts the idle phase short.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      pwm_output_pin <= 1'b0;
    else if (!is_pwm || !ctrl.count_enable)
      pwm_output_pin <= 1'b0;
    else if (trig || start)
      pwm_output_pin <= 1'b1;
    else if (match1)
      pwm_output_pin <= 1'b0;
    else if (match0)
      pwm_output_pin <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (paddr == timer_pkg::OFF_CTRL)
      rd_val = {27'h0000000, ctrl};
    else if (paddr == timer_pkg::OFF_EDGE)
      rd_val = {28'h0000000, edge_ctl};
    else if (paddr == timer_pkg::OFF_CMP0)
      rd_val = {16'h0000, cmp0};
    else if (paddr == timer_pkg::OFF_CMP1)
      rd_val = {16'h0000, cmp1};
    else if (paddr == timer_pkg::OFF_CAP0)
      rd_val = {16'h0000, cap0};
    else if (paddr == timer_pkg::OFF_CAP1)
      rd_val = {16'h0000, cap1};
    else if (paddr == timer_pkg::OFF_COUNT)
      rd_val = {16'h0000, counter};
  end

  // Read data is latched in the setup cycle and held through the access.
  always_ff @(posedge ref_clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_val;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_sync_n);

  sequence s_batch_pending;
    xfer_req && !wr_cmp1 && !wr_ctrl;
  endsequence

  sequence s_transfer_point;
    match0 && !trig;
  endsequence

  a_pulse_start_gate: assert property (
    is_pulse && !ctrl.count_enable |=> counter == timer_pkg::CNT_CLEAR)
    else $error("pulse counter moved without count enable");

  a_capture_copy: assert property (
    cap_hit0 |=> cap0 == $past(counter) && counter == timer_pkg::CNT_CLEAR
                 && capture_interrupt_request[0])
    else $error("capture did not copy, clear and interrupt");

  a_anytime_load: assert property (
    ctrl.rewrite_mode && wr_cmp0 && !start |=> buf0 == $past(pwdata[15:0]))
    else $error("anytime compare zero write not loaded at once");

  a_event_start: assert property (
    start && is_event && $past(is_event && !ctrl.count_enable)
    |-> counter == timer_pkg::CNT_TOP
    ##1 counter == timer_pkg::CNT_CLEAR && buf0 == $past(cmp0))
    else $error("event start did not clear counter and load buffer");

  a_event_match: assert property (
    is_event && match0 |=> counter == timer_pkg::CNT_CLEAR
                           && compare_zero_interrupt)
    else $error("event match did not clear and interrupt");

  a_trig_clear: assert property (
    trig |=> counter == timer_pkg::CNT_CLEAR)
    else $error("trigger did not clear counter");

  a_trig_suppress: assert property (
    trig && match0 |=> !compare_zero_interrupt && pwm_output_pin)
    else $error("trigger did not suppress match interrupt");

  a_zero_compare: assert property (
    is_interval && running && buf0 == timer_pkg::CNT_CLEAR && count_tick
    && counter == timer_pkg::CNT_CLEAR
    |=> compare_zero_interrupt && counter == timer_pkg::CNT_CLEAR
        && timer_output_zero != $past(timer_output_zero))
    else $error("zero compare did not interrupt every tick");

  a_square_wave: assert property (
    is_interval && match0 && match1
    |=> compare_zero_interrupt && compare_one_interrupt
        && timer_output_one != $past(timer_output_one))
    else $error("equal compares did not fire together");

  a_cmp1_toggle: assert property (
    is_interval && match1 |=> timer_output_one != $past(timer_output_one))
    else $error("compare one match did not toggle output one");

  a_rewrite_bit: assert property (
    wr_ctrl |=> ctrl.rewrite_mode == $past(pwdata[timer_pkg::REWRITE_POS]))
    else $error("rewrite mode bit not written");

  a_xfer_set: assert property (
    wr_cmp1 && !ctrl.rewrite_mode |=> xfer_req)
    else $error("batch write did not raise transfer request");

  a_xfer_mode_clear: assert property (
    wr_ctrl && pwdata[timer_pkg::REWRITE_POS] |=> !xfer_req)
    else $error("rewrite mode set did not drop request");

  a_xfer_point: assert property (
    s_batch_pending ##0 s_transfer_point ##0 (!start && !ctrl.rewrite_mode)
    |=> !xfer_req && buf0 == $past(cmp0) && buf1 == $past(cmp1))
    else $error("batch transfer not done at compare zero clear");

endmodule // timer_event_counter

// *** tb/ext_inputs.sv ***
// ---------------------------------------------------------------
// Far-side source of count ticks, capture, event and trigger lines
// ---------------------------------------------------------------
module ext_inputs (
  // Clock
  input wire logic ref_clk,
  // Lines into the timer
  output logic count_tick,
  output logic capture_input_zero,
  output logic capture_input_one,
  output logic ext_trigger
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tick_on = 1'b0;

  initial
  begin
    count_tick = 1'b0;
    capture_input_zero = 1'b0;
    capture_input_one = 1'b0;
    ext_trigger = 1'b0;
  end

  // The chip's count clock is a steady enable while switched on.
  always @(posedge ref_clk)
    count_tick <= tick_on;

  // Event count edges always travel on input zero.
  task drive(input int line, input logic v);
    case (line)
      0: capture_input_zero <= v;
      1: capture_input_one <= v;
      default: ext_trigger <= v;
    endcase
  endtask

  // Levels are held whole cycles so every edge is seen once.
  task pulse(input int line, input int hi, input int lo);
    drive(line, 1'b1);
    repeat (hi) @(posedge ref_clk);
    drive(line, 1'b0);
    repeat (lo) @(posedge ref_clk);
  endtask
endmodule // ext_inputs

// *** tb/sixteen_bit_timer_event_counter_tb.sv ***
// ---------------------------------------------------------------
// Bench for the timer and event counter
// ---------------------------------------------------------------
module sixteen_bit_timer_event_counter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, tick, cap0, cap1, trig;
  logic irq0, irq1, out0, out1, pwm;
  logic [1:0] capreq;
  int mismatches = 0;
  int check_count = 0;
  int n0 = 0, n1 = 0, co = 0, nc = 0, nz = 0, cyc = 0;

  always #25 ref_clk = ~ref_clk;

  timer_event_counter uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_tick(tick),
    .capture_input_zero(cap0), .capture_input_one(cap1),
    .ext_trigger(trig), .compare_zero_interrupt(irq0),
    .compare_one_interrupt(irq1), .capture_interrupt_request(capreq),
    .timer_output_zero(out0), .timer_output_one(out1),
    .pwm_output_pin(pwm)
  );

  ext_inputs ext (
    .ref_clk(ref_clk), .count_tick(tick), .capture_input_zero(cap0),
    .capture_input_one(cap1), .ext_trigger(trig)
  );

  // Counts are sampled on the rising edge; tests clear them on the fall.
  always @(posedge ref_clk)
  begin
    n0 += (irq0 === 1'b1);
    n1 += (irq1 === 1'b1);
    co += (irq0 === 1'b1 && irq1 === 1'b1);
    nc += (capreq[1] === 1'b1);
    nz += (capreq[0] === 1'b1);
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task end_sim;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    n = 1;
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge ref_clk);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16)
    begin
      mismatches++;
      end_sim;
    end
    @(posedge ref_clk);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e);
  endtask

  function automatic logic [31:0] ctl(input logic [2:0] m, input logic ce,
                                      input logic rw);
    return {27'h0000000, rw, m, ce};
  endfunction

  // A wait that runs out ends the run as a mismatch.
  task w0(input int lim);
    cyc = 0;
    do
    begin
      @(posedge ref_clk);
      cyc++;
    end
    while (irq0 !== 1'b1 && cyc < lim);
    if (cyc >= lim)
    begin
      mismatches++;
      end_sim;
    end
  endtask

  task period(input int e);
    w0(200);
    w0(200);
    chk(cyc, e);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs;
    rd(timer_pkg::OFF_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(rerr, 32'h0000_0001);
    wr(timer_pkg::OFF_COUNT, 32'h0000_ffff);
    rd(timer_pkg::OFF_COUNT, 32'h0000_0000);
    $display("test regs done");
  endtask

  task t_event;
    wr(timer_pkg::OFF_EDGE, 32'h0000_0003);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_EVENT, 1'b0, 1'b0));
    rd(timer_pkg::OFF_COUNT, 32'h0000_ffff);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0002);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_EVENT, 1'b1, 1'b0));
    rd(timer_pkg::OFF_COUNT, 32'h0000_0000);
    @(negedge ref_clk);
    n0 = 0;
    @(posedge ref_clk);
    repeat (7) ext.pulse(0, 2, 2);
    repeat (4) @(posedge ref_clk);
    chk(n0, 32'h0000_0004);
    rd(timer_pkg::OFF_COUNT, 32'h0000_0002);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
    $display("test event done");
  endtask

  task t_pulse;
    wr(timer_pkg::OFF_EDGE, 32'h0000_0008);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_PULSE, 1'b0, 1'b0));
    ext.tick_on = 1'b1;
    repeat (5) @(posedge ref_clk);
    rd(timer_pkg::OFF_COUNT, 32'h0000_0000);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_PULSE, 1'b1, 1'b0));
    repeat (2) ext.pulse(1, 3, 7);
    rd(timer_pkg::OFF_CAP1, 32'h0000_0009);
    chk(nc, 32'h0000_0002);
    wr(timer_pkg::OFF_EDGE, 32'h0000_0001);
    repeat (2) ext.pulse(0, 3, 7);
    rd(timer_pkg::OFF_CAP0, 32'h0000_0009);
    chk(nz, 32'h0000_0002);
    $display("test pulse done");
  endtask

  task run_int(input logic [15:0] c0, input logic [15:0] c1,
               input int cn, input int e0, input int e1, input int eco);
    logic s0, s1;
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
    wr(timer_pkg::OFF_CMP0, {16'h0000, c0});
    wr(timer_pkg::OFF_CMP1, {16'h0000, c1});
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_INTERVAL, 1'b1, 1'b0));
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    s0 = out0;
    s1 = out1;
    n0 = 0;
    n1 = 0;
    co = 0;
    repeat (cn) @(negedge ref_clk);
    chk(n0, e0);
    chk(n1, e1);
    chk(co, eco);
    chk(out0, s0 ^ e0[0]);
    chk(out1, s1 ^ e1[0]);
    @(posedge ref_clk);
    $display("test interval done");
  endtask

  task t_batch;
    wr(timer_pkg::OFF_CMP0, 32'h0000_0027);
    wr(timer_pkg::OFF_CMP1, 32'h0000_0027);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_INTERVAL, 1'b1, 1'b0));
    period(40);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0013);
    period(40);
    wr(timer_pkg::OFF_CMP1, 32'h0000_0013);
    period(20);
    wr(timer_pkg::OFF_CMP0, 32'h0000_001d);
    wr(timer_pkg::OFF_CMP1, 32'h0000_001d);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_INTERVAL, 1'b1, 1'b1));
    period(20);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0009);
    period(10);
    $display("test batch done");
  endtask

  task t_trig;
    wr(timer_pkg::OFF_EDGE, 32'h0000_0004);
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0013);
    wr(timer_pkg::OFF_CMP1, 32'h0000_0009);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_PWM_TRIG, 1'b1, 1'b0));
    w0(100);
    ext.pulse(2, 1, 1);
    w0(100);
    chk(cyc + 2 > 20, 32'h0000_0001);
    repeat (17) @(posedge ref_clk);
    @(negedge ref_clk);
    n0 = 0;
    @(posedge ref_clk);
    ext.pulse(2, 1, 1);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(n0, 32'h0000_0000);
    chk(pwm, 32'h0000_0001);
    @(posedge ref_clk);
    $display("test trigger done");
  endtask

  // Lowering compare zero under the count forces a full wrap.
  task t_wrap;
    wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0064);
    wr(timer_pkg::OFF_CTRL, ctl(timer_pkg::MODE_INTERVAL, 1'b1, 1'b1));
    repeat (60) @(posedge ref_clk);
    wr(timer_pkg::OFF_CMP0, 32'h0000_0014);
    w0(70000);
    chk(cyc > 65400 && cyc < 65536, 32'h0000_0001);
    $display("test wrap done");
  endtask

  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs;
    t_event;
    t_pulse;
    run_int(16'h0000, 16'h0000, 9, 9, 9, 9);
    run_int(16'h0004, 16'h0004, 25, 5, 5, 5);
    run_int(16'h0005, 16'h0002, 24, 4, 4, 0);
    t_batch;
    t_trig;
    t_wrap;
    end_sim;
  end
endmodule // sixteen_bit_timer_event_counter_tb
